/* ccdb_pkg.sv */
package ccdb_pkg;
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_DIVIDER   = 8'h00;
  localparam logic [7:0]  OFS_PORT2_M1  = 8'h04;
  localparam logic [7:0]  OFS_AUX_CTL1  = 8'h08;
  localparam logic [7:0]  OFS_PWR_CTL   = 8'h0C;
  localparam logic [7:0]  OFS_INT_EN0   = 8'h10;
  localparam logic [7:0]  OFS_STATUS    = 8'h14;
  localparam int          BIT_CLKOUT_EN = 1;
  localparam int          BIT_BO_INTSEL = 5;
  localparam int          BIT_BO_DIS    = 6;
  localparam int          BIT_BO_FLAG   = 5;
  localparam int          BIT_GLOBAL_IE = 7;
  localparam int          BIT_BO_IE     = 5;
  localparam logic [7:0]  CPU_CLOCK_DIVIDER_VALUE_RESET    = 8'h00;
  localparam logic [2:0]  OSC_RC        = 3'h3;
  localparam logic [2:0]  OSC_EXT       = 3'h4;
  localparam logic [2:0]  MC_LAST_PHASE = 3'h5;
  localparam logic [2:0]  CLKOUT_HIGH_N = 3'h3;
  localparam logic [10:0] PERIOD_ONE    = 11'h001;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

/* ccdb_top.sv */
`timescale 1ns/10ps
module ccdb_top (
  input  wire logic                        CLK_SYS,
  input  wire logic                        RST,
  input  wire logic [2:0]                  OSC_TYPE_CFG,
  input  wire logic                        LEGACY_TIMING_SELECT,
  input  wire logic                        BROWNOUT_LEVEL_SELECT,
  input  wire logic                        OSC_RUNNING,
  input  wire logic                        BROWNOUT_DETECT_ASYNC,
  input  wire logic [ccdb_pkg::ADDR_W-1:0] AWADDR,
  input  wire logic                        AWVALID,
  output logic                             AWREADY,
  input  wire logic [31:0]                 WDATA,
  input  wire logic [3:0]                  WSTRB,
  input  wire logic                        WVALID,
  output logic                             WREADY,
  output logic [1:0]                       BRESP,
  output logic                             BVALID,
  input  wire logic                        BREADY,
  input  wire logic [ccdb_pkg::ADDR_W-1:0] ARADDR,
  input  wire logic                        ARVALID,
  output logic                             ARREADY,
  output logic [31:0]                      RDATA,
  output logic [1:0]                       RRESP,
  output logic                             RVALID,
  input  wire logic                        RREADY,
  output logic                             CPU_CLK_TICK,
  output logic                             MACHINE_CYCLE_TICK,
  output logic                             CLOCK_OUTPUT_PIN_O,
  output logic                             CLOCK_OUTPUT_PIN_OE,
  output logic                             OSC_OUT_PORT_PIN_GPIO,
  output logic                             BROWNOUT_LEVEL_LOW,
  output logic                             CPU_RESET,
  output logic                             BROWNOUT_IRQ
);
  import ccdb_pkg::*;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // Configuration, captured only while reset is held.
  logic [2:0]  osc_q, osc_d;
  logic        legacy_q, legacy_d;
  logic        lvl_q, lvl_d;
  logic        clkout_ok;

  always_comb begin
    osc_d    = RST ? OSC_TYPE_CFG : osc_q;
    legacy_d = RST ? LEGACY_TIMING_SELECT : legacy_q;
    lvl_d    = RST ? BROWNOUT_LEVEL_SELECT : lvl_q;
    clkout_ok = (osc_q == OSC_RC) || (osc_q == OSC_EXT);
  end

  always_ff @(posedge CLK_SYS) begin
    osc_q    <= osc_d;
    legacy_q <= legacy_d;
    lvl_q    <= lvl_d;
  end

  // Software registers.
  logic [7:0] cpu_clock_divider_value_q, cpu_clock_divider_value_d;
  logic       clkout_en_q, clkout_en_d;
  logic       bo_intsel_q, bo_intsel_d;
  logic       bo_dis_q, bo_dis_d;
  logic       bo_flag_q, bo_flag_d;
  logic       ea_q, ea_d;
  logic       ebo_q, ebo_d;

  // AXI4-Lite slave state.
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic              awhave_q, awhave_d;
  logic [7:0]        wbyte_q, wbyte_d;
  logic              wlane_q, wlane_d;
  logic              whave_q, whave_d;
  logic              awrdy_q, awrdy_d;
  logic              wrdy_q, wrdy_d;
  logic              bvalid_q, bvalid_d;
  logic [1:0]        bresp_q, bresp_d;
  logic              arrdy_q, arrdy_d;
  logic              rvalid_q, rvalid_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [1:0]        rresp_q, rresp_d;
  logic              wr_go;
  logic              wr_hit;
  logic              rd_hit;
  logic              power_control_reg_clear;

  // Brownout state.
  logic bo_s1_q, bo_s2_q, bo_prev_q;
  logic rst_out_q, rst_out_d;
  logic irq_q, irq_d;
  logic bo_active;
  logic bo_rise;

  always_comb begin
    bo_active = bo_s2_q && !bo_dis_q;
    bo_rise   = bo_s2_q && !bo_prev_q && !bo_dis_q;
    rst_out_d = bo_active && !bo_intsel_q;
    irq_d     = bo_rise && bo_intsel_q && ea_q && ebo_q;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      bo_s1_q   <= 1'b0;
      bo_s2_q   <= 1'b0;
      bo_prev_q <= 1'b0;
      rst_out_q <= 1'b1;
      irq_q     <= 1'b0;
    end else begin
      bo_s1_q   <= BROWNOUT_DETECT_ASYNC;
      bo_s2_q   <= bo_s1_q;
      bo_prev_q <= bo_s2_q;
      rst_out_q <= rst_out_d;
      irq_q     <= irq_d;
    end
  end

  always_comb begin
    awaddr_d = awaddr_q;
    awhave_d = awhave_q;
    wbyte_d  = wbyte_q;
    wlane_d  = wlane_q;
    whave_d  = whave_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    arrdy_d  = arrdy_q;
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    cpu_clock_divider_value_d      = cpu_clock_divider_value_q;
    clkout_en_d = clkout_en_q;
    bo_intsel_d = bo_intsel_q;
    bo_dis_d    = bo_dis_q;
    ea_d        = ea_q;
    ebo_d       = ebo_q;
    power_control_reg_clear  = 1'b0;
    wr_hit      = 1'b0;
    rd_hit      = 1'b1;
    if (AWVALID && awrdy_q) begin
      awaddr_d = AWADDR;
      awhave_d = 1'b1;
    end
    if (WVALID && wrdy_q) begin
      wbyte_d = WDATA[7:0];
      wlane_d = WSTRB[0];
      whave_d = 1'b1;
    end
    if (BREADY && bvalid_q) begin
      bvalid_d = 1'b0;
    end
    wr_go = awhave_q && whave_q && !bvalid_q;
    if (wr_go) begin
      awhave_d = 1'b0;
      whave_d  = 1'b0;
      bvalid_d = 1'b1;
      wr_hit   = 1'b1;
      unique case (awaddr_q)
        OFS_DIVIDER: begin
          if (wlane_q) begin
            cpu_clock_divider_value_d = wbyte_q;
          end
        end
        OFS_PORT2_M1: begin
          if (wlane_q) begin
            clkout_en_d = wbyte_q[BIT_CLKOUT_EN];
          end
        end
        OFS_AUX_CTL1: begin
          if (wlane_q) begin
            bo_intsel_d = wbyte_q[BIT_BO_INTSEL];
            bo_dis_d    = wbyte_q[BIT_BO_DIS];
          end
        end
        OFS_PWR_CTL: begin
          power_control_reg_clear = wlane_q && !wbyte_q[BIT_BO_FLAG];
        end
        OFS_INT_EN0: begin
          if (wlane_q) begin
            ea_d  = wbyte_q[BIT_GLOBAL_IE];
            ebo_d = wbyte_q[BIT_BO_IE];
          end
        end
        OFS_STATUS: begin
          wr_hit = 1'b1;
        end
        default: begin
          wr_hit = 1'b0;
        end
      endcase
      bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    awrdy_d = !awhave_d;
    wrdy_d  = !whave_d;
    if (RREADY && rvalid_q) begin
      rvalid_d = 1'b0;
      arrdy_d  = 1'b1;
    end
    if (ARVALID && arrdy_q) begin
      rvalid_d = 1'b1;
      arrdy_d  = 1'b0;
      rdata_d  = 32'h0000_0000;
      unique case (ARADDR)
        OFS_DIVIDER:  rdata_d[7:0] = cpu_clock_divider_value_q;
        OFS_PORT2_M1: rdata_d[BIT_CLKOUT_EN] = clkout_en_q;
        OFS_AUX_CTL1: begin
          rdata_d[BIT_BO_INTSEL] = bo_intsel_q;
          rdata_d[BIT_BO_DIS]    = bo_dis_q;
        end
        OFS_PWR_CTL:  rdata_d[BIT_BO_FLAG] = bo_flag_q;
        OFS_INT_EN0: begin
          rdata_d[BIT_GLOBAL_IE] = ea_q;
          rdata_d[BIT_BO_IE]     = ebo_q;
        end
        OFS_STATUS:   rdata_d[6:0] = {rst_out_q, bo_active, lvl_q, legacy_q, osc_q};
        default:      rd_hit = 1'b0;
      endcase
      rresp_d = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    bo_flag_d = bo_rise || (bo_flag_q && !power_control_reg_clear);
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      awaddr_q    <= '0;
      awhave_q    <= 1'b0;
      wbyte_q     <= 8'h00;
      wlane_q     <= 1'b0;
      whave_q     <= 1'b0;
      awrdy_q     <= 1'b1;
      wrdy_q      <= 1'b1;
      bvalid_q    <= 1'b0;
      bresp_q     <= RESP_OKAY;
      arrdy_q     <= 1'b1;
      rvalid_q    <= 1'b0;
      rdata_q     <= 32'h0000_0000;
      rresp_q     <= RESP_OKAY;
      cpu_clock_divider_value_q      <= CPU_CLOCK_DIVIDER_VALUE_RESET;
      clkout_en_q <= 1'b0;
      bo_intsel_q <= 1'b0;
      bo_dis_q    <= 1'b0;
      bo_flag_q   <= 1'b0;
      ea_q        <= 1'b0;
      ebo_q       <= 1'b0;
    end else begin
      awaddr_q    <= awaddr_d;
      awhave_q    <= awhave_d;
      wbyte_q     <= wbyte_d;
      wlane_q     <= wlane_d;
      whave_q     <= whave_d;
      awrdy_q     <= awrdy_d;
      wrdy_q      <= wrdy_d;
      bvalid_q    <= bvalid_d;
      bresp_q     <= bresp_d;
      arrdy_q     <= arrdy_d;
      rvalid_q    <= rvalid_d;
      rdata_q     <= rdata_d;
      rresp_q     <= rresp_d;
      cpu_clock_divider_value_q      <= cpu_clock_divider_value_d;
      clkout_en_q <= clkout_en_d;
      bo_intsel_q <= bo_intsel_d;
      bo_dis_q    <= bo_dis_d;
      bo_flag_q   <= bo_flag_d;
      ea_q        <= ea_d;
      ebo_q       <= ebo_d;
    end
  end

  // CPU clock divider and clock output.
  logic [10:0] cnt_q, cnt_d;
  logic [10:0] period_q, period_d;
  logic [10:0] period_new;
  logic        tick_now;
  logic        tick_q;
  logic [2:0]  phase_q, phase_d;
  logic        clkout_q, clkout_d;
  logic        oe_q, oe_d;
  logic        gpio_q, gpio_d;
  logic        mtick_q, mtick_d;

  always_comb begin
    // ratio two times N plus two, one when N is zero
    if (cpu_clock_divider_value_q == CPU_CLOCK_DIVIDER_VALUE_RESET) begin
      period_new = PERIOD_ONE;
    end else begin
      period_new = {2'b00, cpu_clock_divider_value_q, 1'b0} + 11'h002;
    end
    if (legacy_q) begin
      period_new = {period_new[9:0], 1'b0};
    end
    tick_now = (cnt_q == period_q - PERIOD_ONE);
    cnt_d    = tick_now ? 11'h000 : cnt_q + 11'h001;
    period_d = tick_now ? period_new : period_q;
    phase_d  = phase_q;
    mtick_d  = 1'b0;
    if (tick_q) begin
      phase_d = (phase_q == MC_LAST_PHASE) ? 3'h0 : phase_q + 3'h1;
      mtick_d = (phase_q == MC_LAST_PHASE);
    end
    clkout_d = (phase_d < CLKOUT_HIGH_N);
    oe_d     = clkout_en_q && clkout_ok && OSC_RUNNING;
    gpio_d   = (osc_q == OSC_EXT) && !clkout_en_q;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cnt_q    <= 11'h000;
      period_q <= PERIOD_ONE;
      tick_q   <= 1'b0;
      phase_q  <= 3'h0;
      clkout_q <= 1'b0;
      oe_q     <= 1'b0;
      gpio_q   <= 1'b0;
      mtick_q  <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      period_q <= period_d;
      tick_q   <= tick_now;
      phase_q  <= phase_d;
      clkout_q <= clkout_d;
      oe_q     <= oe_d;
      gpio_q   <= gpio_d;
      mtick_q  <= mtick_d;
    end
  end

  assign AWREADY               = awrdy_q;
  assign WREADY                = wrdy_q;
  assign BVALID                = bvalid_q;
  assign BRESP                 = bresp_q;
  assign ARREADY               = arrdy_q;
  assign RVALID                = rvalid_q;
  assign RDATA                 = rdata_q;
  assign RRESP                 = rresp_q;
  assign CPU_CLK_TICK          = tick_q;
  assign MACHINE_CYCLE_TICK    = mtick_q;
  assign CLOCK_OUTPUT_PIN_O    = clkout_q;
  assign CLOCK_OUTPUT_PIN_OE   = oe_q;
  assign OSC_OUT_PORT_PIN_GPIO = gpio_q;
  assign BROWNOUT_LEVEL_LOW    = lvl_q;
  assign CPU_RESET             = rst_out_q;
  assign BROWNOUT_IRQ          = irq_q;

  // Configuration must not move once running.
  chk_cfg_fixed: assert property (!$past(RST) |-> $stable(osc_q) && $stable(legacy_q))
    else $error("configuration changed after reset");
  chk_clkout_source: assert property (CLOCK_OUTPUT_PIN_OE |-> clkout_ok)
    else $error("clock output driven from a crystal source");
  chk_clkout_run: assert property (clkout_en_q && clkout_ok && OSC_RUNNING |=> CLOCK_OUTPUT_PIN_OE)
    else $error("clock output not driven while enabled");
  chk_clkout_half: assert property (tick_q && phase_q == 3'h2 |=> !CLOCK_OUTPUT_PIN_O)
    else $error("clock output high phase not three clocks");
  chk_gpio_release: assert property (osc_q == OSC_EXT && !clkout_en_q |=> OSC_OUT_PORT_PIN_GPIO)
    else $error("second pin not released");
  chk_mcycle_six: assert property (MACHINE_CYCLE_TICK |-> $past(phase_q) == MC_LAST_PHASE && $past(tick_q))
    else $error("machine cycle not six clocks");
  chk_div_zero: assert property (period_q == PERIOD_ONE |=> tick_q)
    else $error("undivided clock missed a tick");
  chk_div_ratio: assert property (tick_q |-> $past(cnt_q) == $past(period_q) - PERIOD_ONE)
    else $error("divided period wrong");
  chk_div_boundary: assert property (!$past(tick_now) |-> $stable(period_q))
    else $error("divider changed mid period");
  chk_bo_reset: assert property (bo_active && !bo_intsel_q |=> CPU_RESET)
    else $error("brownout reset not held");
  chk_bo_once: assert property (BROWNOUT_IRQ |=> !BROWNOUT_IRQ)
    else $error("brownout interrupt repeated");
  chk_irq_gate: assert property (BROWNOUT_IRQ |-> $past(ea_q) && $past(ebo_q))
    else $error("brownout interrupt without enables");
  chk_flag_set: assert property (bo_rise |=> bo_flag_q)
    else $error("brownout flag not set");
  chk_flag_hold: assert property (bo_flag_q && !power_control_reg_clear |=> bo_flag_q)
    else $error("brownout flag lost");
  chk_bo_disabled: assert property (bo_dis_q |=> !BROWNOUT_IRQ && !$rose(bo_flag_q))
    else $error("disabled brownout still acted");
  chk_sync_depth: assert property (bo_s2_q == $past(BROWNOUT_DETECT_ASYNC, 2) || $past(RST, 2))
    else $error("synchroniser depth wrong");

  cov_irq: cover property (BROWNOUT_IRQ);
  cov_reset: cover property (bo_active && CPU_RESET);
  cov_div_switch: cover property (tick_now && period_new != period_q);
  cov_clkout: cover property (CLOCK_OUTPUT_PIN_OE && $rose(CLOCK_OUTPUT_PIN_O));
endmodule

/* ccdb_partner.sv */
`timescale 1ns/10ps
module ccdb_partner (
  input  wire logic clk,
  input  wire logic cpu_tick,
  input  wire logic mc_tick,
  input  wire logic clk_out,
  input  wire logic clk_oe,
  input  wire logic irq,
  input  wire logic supply_low,
  output logic      detect_async,
  output int        n_tick,
  output int        n_mc,
  output int        n_co,
  output int        n_irq
);
  logic co_q;

  initial begin
    detect_async = 1'b0;
    co_q = 1'b0;
    n_tick = 0;
    n_mc = 0;
    n_co = 0;
    n_irq = 0;
  end

  // detector level hold.
  // The analog detector is unrelated to the clock, so it answers off the edge.
  always @(supply_low) detect_async <= #37 supply_low;

  always @(posedge clk) begin
    co_q <= clk_out;
    if (cpu_tick) n_tick <= n_tick + 1;
    if (mc_tick) n_mc <= n_mc + 1;
    // Only a driven pin reaches the far side, so an undriven clock output counts nothing.
    if (clk_out && clk_oe && !co_q) n_co <= n_co + 1;
    if (irq) n_irq <= n_irq + 1;
  end
endmodule

/* ccdb_top_tb_top.sv */
`timescale 1ns/10ps
module ccdb_top_tb_top;
  import ccdb_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  osc = OSC_RC;
  logic        legacy = 1'b0, lvl = 1'b1, osc_run = 1'b1, supply_low = 1'b0, det;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp, rr;
  // Response ready stays high for the whole run, so no task lowers and raises it in one step.
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        cpu_tick, mc_tick, co, co_oe, gpio, lvl_low, cpu_rst, irq;
  int          n_tick, n_mc, n_co, n_irq;
  int          mismatches = 0, check_count = 0, cycles = 0;

  ccdb_top i_dut (
    .CLK_SYS(clk), .RST(rst), .OSC_TYPE_CFG(osc), .LEGACY_TIMING_SELECT(legacy),
    .BROWNOUT_LEVEL_SELECT(lvl), .OSC_RUNNING(osc_run), .BROWNOUT_DETECT_ASYNC(det),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready), .CPU_CLK_TICK(cpu_tick), .MACHINE_CYCLE_TICK(mc_tick),
    .CLOCK_OUTPUT_PIN_O(co), .CLOCK_OUTPUT_PIN_OE(co_oe), .OSC_OUT_PORT_PIN_GPIO(gpio),
    .BROWNOUT_LEVEL_LOW(lvl_low), .CPU_RESET(cpu_rst), .BROWNOUT_IRQ(irq));

  ccdb_partner i_far (
    .clk(clk), .cpu_tick(cpu_tick), .mc_tick(mc_tick), .clk_out(co), .clk_oe(co_oe), .irq(irq),
    .supply_low(supply_low), .detect_async(det), .n_tick(n_tick), .n_mc(n_mc),
    .n_co(n_co), .n_irq(n_irq));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // The whole run needs about 16300 cycles, so this ceiling leaves ample margin.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      mismatches = mismatches + 1;
      summarize();
    end
  end

  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= s;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    chk_v({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
    chk_v(rd, e);
    chk_v({30'h0, rr}, {30'h0, er});
  endtask

  // A window of whole periods holds an exact number of pulses, whatever the phase.
  task automatic measure(input int p, input int e_co);
    int t0, m0, c0;
    t0 = n_tick;
    m0 = n_mc;
    c0 = n_co;
    wait_n(24 * p);
    chk_n(n_tick - t0, 24);
    chk_n(n_mc - m0, 4);
    chk_n(n_co - c0, e_co);
  endtask

  task automatic do_reset(input logic [2:0] o, input logic l, input logic v);
    osc <= o;
    legacy <= l;
    lvl <= v;
    rst <= 1'b1;
    wait_n(2);
    rst <= 1'b0;
    wait_n(3);
  endtask

  task automatic brown(input int n, input int e_irq);
    int i0;
    i0 = n_irq;
    supply_low <= 1'b1;
    wait_n(n);
    chk_v({31'h0, cpu_rst}, 32'h0);
    supply_low <= 1'b0;
    wait_n(10);
    chk_n(n_irq - i0, e_irq);
  endtask

  initial begin
    int np [3] = '{0, 1, 255};
    int pp [3] = '{1, 4, 512};
    do_reset(OSC_RC, 1'b0, 1'b1);
    chk_v({31'h0, cpu_rst}, 32'h0);
    chk_v({31'h0, lvl_low}, 32'h1);
    rd_chk(OFS_STATUS, 32'h13, RESP_OKAY);
    rd_chk(OFS_DIVIDER, {24'h0, CPU_CLOCK_DIVIDER_VALUE_RESET}, RESP_OKAY);
    axi_wr(OFS_DIVIDER, 8'h07, 4'h0, RESP_OKAY);
    rd_chk(OFS_DIVIDER, 32'h0, RESP_OKAY);
    axi_wr(8'h18, 8'h01, 4'hF, RESP_SLVERR);
    rd_chk(8'h18, 32'h0, RESP_SLVERR);
    $display("test reset finished");
    axi_wr(OFS_PORT2_M1, 8'h02, 4'hF, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      axi_wr(OFS_DIVIDER, np[i][7:0], 4'hF, RESP_OKAY);
      wait_n(1100);
      measure(pp[i], 4);
    end
    chk_v({31'h0, co_oe}, 32'h1);
    osc_run <= 1'b0;
    wait_n(3);
    chk_v({31'h0, co_oe}, 32'h0);
    osc_run <= 1'b1;
    axi_wr(OFS_DIVIDER, 8'h00, 4'hF, RESP_OKAY);
    $display("test divider finished");
    supply_low <= 1'b1;
    wait_n(8);
    chk_v({31'h0, cpu_rst}, 32'h1);
    rd_chk(OFS_STATUS, 32'h73, RESP_OKAY);
    rd_chk(OFS_PWR_CTL, 32'h20, RESP_OKAY);
    supply_low <= 1'b0;
    wait_n(8);
    chk_v({31'h0, cpu_rst}, 32'h0);
    rd_chk(OFS_PWR_CTL, 32'h20, RESP_OKAY);
    axi_wr(OFS_PWR_CTL, 8'h00, 4'hF, RESP_OKAY);
    rd_chk(OFS_PWR_CTL, 32'h0, RESP_OKAY);
    $display("test brownout reset finished");
    axi_wr(OFS_AUX_CTL1, 8'h20, 4'hF, RESP_OKAY);
    axi_wr(OFS_INT_EN0, 8'hA0, 4'hF, RESP_OKAY);
    brown(50, 1);
    axi_wr(OFS_INT_EN0, 8'h20, 4'hF, RESP_OKAY);
    brown(20, 0);
    axi_wr(OFS_INT_EN0, 8'h80, 4'hF, RESP_OKAY);
    brown(20, 0);
    rd_chk(OFS_PWR_CTL, 32'h20, RESP_OKAY);
    $display("test brownout interrupt finished");
    axi_wr(OFS_PWR_CTL, 8'h00, 4'hF, RESP_OKAY);
    axi_wr(OFS_INT_EN0, 8'hA0, 4'hF, RESP_OKAY);
    axi_wr(OFS_AUX_CTL1, 8'h60, 4'hF, RESP_OKAY);
    brown(20, 0);
    axi_wr(OFS_AUX_CTL1, 8'h40, 4'hF, RESP_OKAY);
    brown(20, 0);
    rd_chk(OFS_PWR_CTL, 32'h0, RESP_OKAY);
    $display("test brownout disable finished");
    do_reset(OSC_EXT, 1'b1, 1'b0);
    chk_v({31'h0, lvl_low}, 32'h0);
    chk_v({31'h0, gpio}, 32'h1);
    rd_chk(OFS_STATUS, 32'h0C, RESP_OKAY);
    measure(2, 0);
    axi_wr(OFS_PORT2_M1, 8'h02, 4'hF, RESP_OKAY);
    wait_n(3);
    chk_v({31'h0, gpio}, 32'h0);
    chk_v({31'h0, co_oe}, 32'h1);
    axi_wr(OFS_DIVIDER, 8'h01, 4'hF, RESP_OKAY);
    wait_n(40);
    measure(8, 4);
    do_reset(3'h2, 1'b0, 1'b1);
    axi_wr(OFS_PORT2_M1, 8'h02, 4'hF, RESP_OKAY);
    wait_n(3);
    chk_v({31'h0, co_oe}, 32'h0);
    chk_v({31'h0, gpio}, 32'h0);
    $display("test legacy and source finished");
    summarize();
  end
endmodule
